//--- hw/cfbu_core.sv
`timescale 1ns/1ps
// What this block does
// - opcode e3 branches when carry is zero.
// - opcode e7 branches when negative is zero.
// - opcode e6 branches when negative is one.
// - low byte is signed offset, doubled.
// - target is incremented address plus twice offset.
// - one cycle untaken, two cycles taken.
// - taken: decode, read, process, write, idle cycle.
// - untaken: three phases work, fourth does nothing.
module cfbu_core
  import cfbu_pkg::*;
#(
  parameter int PC_WIDTH = 21
) (
  // Clock and reset.
  input  wire logic                clk,
  input  wire logic                reset,
  // Instruction and state from fetch.
  input  wire logic                instr_valid,
  input  wire logic [15:0]         instr_word,
  input  wire logic [PC_WIDTH-1:0] pc_next,
  input  wire logic                carry_flag,
  input  wire logic                negative_flag,
  // Program counter control to fetch.
  output logic      [PC_WIDTH-1:0] pc_load_value,
  output logic                     pc_load,
  output logic                     flush_prefetch,
  output logic                     busy,
  output logic                     branch_done,
  output logic      [1:0]          phase
);
  // =====================================================================
  // Elaboration checks.
  if (PC_WIDTH < 10 || PC_WIDTH > 32) begin : g_bad_width
    $error("PC_WIDTH must lie between 10 and 32.");
  end

  // =====================================================================
  // Decode.
  cfbu_state_t                 state;
  cfbu_state_t                 next_state;
  logic        [1:0]           next_phase;
  logic        [15:0]          held_word;
  logic                        held_cond;
  logic        [PC_WIDTH-1:0]  target;

  // The opcode is latched in decode so a later change on the bus cannot
  // corrupt the branch halfway through its cycle.
  wire logic [7:0] op_hi        = held_word[15:CFBU_OP_HI_LSB];
  wire logic       is_carry_clr = (op_hi == CFBU_OP_CARRY_CLEAR);
  wire logic       is_neg_clr   = (op_hi == CFBU_OP_NEGATIVE_CLEAR);
  wire logic       is_neg_set   = (op_hi == CFBU_OP_NEGATIVE_SET);
  wire logic       is_branch    = is_carry_clr | is_neg_clr | is_neg_set;
  wire logic       cond_now     = (is_carry_clr & ~carry_flag)
                                | (is_neg_clr & ~negative_flag)
                                | (is_neg_set & negative_flag);
  // Sign extend and double the offset.
  wire logic [PC_WIDTH-1:0] offset2 =
    {{(PC_WIDTH-9){held_word[CFBU_OFFSET_MSB]}}, held_word[7:0], 1'b0};
  // Fetch has already stepped one word past the branch.
  wire logic [PC_WIDTH-1:0] next_target = pc_next + offset2;
  wire logic last_phase = (phase == CFBU_PH_WRITE);
  wire logic taken_end  = (state == CFBU_EXEC) && last_phase && held_cond;

  // Phase counter and cycle state.
  always_comb begin
    next_phase = phase + 2'h1;
    next_state = state;
    if (last_phase) begin
      next_state = taken_end ? CFBU_IDLE : CFBU_EXEC;
    end
  end

  // =====================================================================
  // Sequencing.
  always_ff @(posedge clk) begin
    if (reset) begin
      state          <= CFBU_EXEC;
      phase          <= CFBU_PHASE_RESET;
      held_word      <= 16'h0000;
      held_cond      <= 1'b0;
      target         <= '0;
      pc_load        <= 1'b0;
      pc_load_value  <= '0;
      flush_prefetch <= 1'b0;
      busy           <= 1'b0;
      branch_done    <= 1'b0;
    end else begin
      state <= next_state;
      phase <= next_phase;
      if (state == CFBU_EXEC && phase == CFBU_PH_DECODE) begin
        held_word <= instr_valid ? instr_word : 16'h0000;
      end
      // Flags are sampled in process so their latest value decides.
      if (state == CFBU_EXEC && phase == CFBU_PH_PROCESS) begin
        held_cond <= is_branch & cond_now;
        target    <= next_target;
      end
      // Untaken branches leave the counter alone in the fourth phase.
      pc_load        <= (state == CFBU_EXEC) && (phase == CFBU_PH_PROCESS)
                        && is_branch && cond_now;
      pc_load_value  <= next_target;
      flush_prefetch <= taken_end;
      busy           <= (next_state == CFBU_IDLE);
      branch_done    <= last_phase && ((state == CFBU_IDLE) ||
                        (is_branch && !held_cond));
    end
  end

  // =====================================================================
  // Checks.
  sequence s_write_then_idle;
    pc_load ##1 (busy && !pc_load)[*4];
  endsequence

  a_taken_loads_idle: assert property (@(posedge clk) disable iff (reset)
    $rose(pc_load) |-> s_write_then_idle)
    else $error("Taken branch did not idle four phases.");
  a_load_phase: assert property (@(posedge clk) disable iff (reset)
    pc_load |-> phase == CFBU_PH_WRITE)
    else $error("Counter written outside the fourth phase.");
  a_flush_after_load: assert property (@(posedge clk) disable iff (reset)
    pc_load |=> flush_prefetch)
    else $error("Prefetch not flushed after taken branch.");
  a_target_value: assert property (@(posedge clk) disable iff (reset)
    pc_load |-> pc_load_value == target)
    else $error("Loaded counter differs from computed target.");
  a_untaken_no_load: assert property (@(posedge clk) disable iff (reset)
    (state == CFBU_EXEC && phase == CFBU_PH_PROCESS && is_branch && !cond_now)
      |=> !pc_load ##1 !busy)
    else $error("Untaken branch touched the counter.");
  a_carry_clear: assert property (@(posedge clk) disable iff (reset)
    (state == CFBU_EXEC && phase == CFBU_PH_PROCESS && is_carry_clr)
      |=> pc_load == $past(!carry_flag))
    else $error("Carry clear branch decision wrong.");
  a_neg_clear: assert property (@(posedge clk) disable iff (reset)
    (state == CFBU_EXEC && phase == CFBU_PH_PROCESS && is_neg_clr)
      |=> pc_load == $past(!negative_flag))
    else $error("Negative clear branch decision wrong.");
  a_neg_set: assert property (@(posedge clk) disable iff (reset)
    (state == CFBU_EXEC && phase == CFBU_PH_PROCESS && is_neg_set)
      |=> pc_load == $past(negative_flag))
    else $error("Negative set branch decision wrong.");
  // The step from the incremented address must be twice the signed low byte.
  // The held word still stands in the write phase, so it can be read there.
  a_offset_double: assert property (@(posedge clk) disable iff (reset)
    (state == CFBU_EXEC && phase == CFBU_PH_PROCESS && is_branch)
      |=> (pc_load_value - $past(pc_next))
          == PC_WIDTH'($signed(held_word[7:0]) * 2))
    else $error("Offset not doubled.");
  // Done is reported at the first phase after the idle cycle, five clocks
  // after the counter write.
  a_two_cycles: assert property (@(posedge clk) disable iff (reset)
    $rose(pc_load) |-> ##5 branch_done)
    else $error("Taken branch not done after two cycles.");

  // =====================================================================
  // Further checks on the cycle timing.
  // A taken branch costs eight clocks and an untaken one four.  The
  // checks below pin every output but pc_load_value to its phase, so that a slip of one
  // clock in the sequencer is seen at once rather than as a wrong counter
  // value several instructions later in the fetch logic.

  // Shape of the end of an untaken branch: no write, then a done pulse.
  sequence s_untaken_end;
    !pc_load ##1 (!busy && branch_done);
  endsequence

  // Shape of the end of a non-branch word: no write, no busy, no done pulse.
  sequence s_quiet_end;
    !pc_load ##1 (!busy && !branch_done);
  endsequence

  // The flush is a single clock pulse.
  a_flush_one_clock: assert property (@(posedge clk) disable iff (reset)
    flush_prefetch |=> !flush_prefetch)
    else $error("Prefetch flush longer than one clock.");

  // The flush falls in the first phase of the idle cycle.
  a_flush_in_idle: assert property (@(posedge clk) disable iff (reset)
    flush_prefetch |-> busy && phase == CFBU_PH_DECODE)
    else $error("Prefetch flush outside the idle cycle.");

  // Busy stands exactly four phases.
  a_busy_four: assert property (@(posedge clk) disable iff (reset)
    $rose(busy) |-> busy[*4] ##1 !busy)
    else $error("Idle cycle not four phases long.");

  // An untaken branch reports done one cycle after decode.
  a_untaken_done: assert property (@(posedge clk) disable iff (reset)
    (state == CFBU_EXEC && phase == CFBU_PH_PROCESS && is_branch && !cond_now)
      |=> s_untaken_end)
    else $error("Untaken branch did not finish in one cycle.");

  // Words that are not one of the three branches never load, idle or report done.
  a_non_branch_quiet: assert property (@(posedge clk) disable iff (reset)
    (state == CFBU_EXEC && phase == CFBU_PH_PROCESS && !is_branch)
      |=> s_quiet_end)
    else $error("Non-branch word acted as a branch.");

  // The phase counter wraps from write back to decode.
  a_phase_wrap: assert property (@(posedge clk) disable iff (reset)
    phase == CFBU_PH_WRITE |=> phase == CFBU_PH_DECODE)
    else $error("Phase counter did not wrap.");

  // The phase counter steps from decode to literal.
  a_phase_step: assert property (@(posedge clk) disable iff (reset)
    phase == CFBU_PH_DECODE |=> phase == CFBU_PH_LITERAL)
    else $error("Phase counter did not step.");

  // The idle cycle never writes the counter again.
  a_idle_no_load: assert property (@(posedge clk) disable iff (reset)
    state == CFBU_IDLE |-> !pc_load)
    else $error("Counter written during the idle cycle.");

  // Done is never reported while the idle cycle still runs.
  a_busy_no_done: assert property (@(posedge clk) disable iff (reset)
    busy |-> !branch_done)
    else $error("Branch reported done while busy.");
endmodule

//--- hw/cfbu_pkg.sv
// =====================================================================
// Shared constants for the conditional flag branch unit.
package cfbu_pkg;
  // =====================================================================
  // Opcode upper-byte codes.
  localparam logic [7:0] CFBU_OP_CARRY_CLEAR    = 8'he3;
  localparam logic [7:0] CFBU_OP_NEGATIVE_SET   = 8'he6;
  localparam logic [7:0] CFBU_OP_NEGATIVE_CLEAR = 8'he7;
  // Field positions inside the 16-bit opcode.
  localparam int CFBU_OP_HI_LSB  = 8;
  localparam int CFBU_OFFSET_MSB = 7;
  // Byte step from one instruction word to the next.
  localparam int CFBU_WORD_BYTES = 2;
  // Reset values.
  localparam logic [1:0] CFBU_PHASE_RESET = 2'h0;
  // Phase numbers, zero based: phase one is code 0.
  localparam logic [1:0] CFBU_PH_DECODE  = 2'h0;
  localparam logic [1:0] CFBU_PH_LITERAL = 2'h1;
  localparam logic [1:0] CFBU_PH_PROCESS = 2'h2;
  localparam logic [1:0] CFBU_PH_WRITE   = 2'h3;
  // Instruction cycle states.
  typedef enum logic [0:0] {CFBU_EXEC, CFBU_IDLE} cfbu_state_t;
endpackage

//--- dv/cfbu_fetch_model.sv
`timescale 1ns/1ps
// ==========
// Fetch side: holds the counter and follows every load of the unit.
module cfbu_fetch_model #(
  parameter int W = 21
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         reset,
  // Unit outputs.
  input  wire logic [1:0]   phase,
  input  wire logic         busy,
  input  wire logic         pc_load,
  input  wire logic [W-1:0] pc_load_value,
  // Incremented fetch address.
  output logic      [W-1:0] pc_next
);
  logic [W-1:0] pc;
  // The fetch has already stepped one word past the current one.
  assign pc_next = pc + W'(2);
  // A load wins; otherwise the end of a working cycle steps on.
  always_ff @(posedge clk) begin
    if (reset) begin
      pc <= W'(32'h100);
    end else if (pc_load) begin
      pc <= pc_load_value;
    end else if (phase == 2'h3 && !busy) begin
      pc <= pc_next;
    end
  end
endmodule

//--- dv/test_conditional_flag_branch_unit.sv
`timescale 1ns/1ps
// ==========
// Random branch words against an integer model of the counter.
module test_conditional_flag_branch_unit
  import cfbu_pkg::*;
;
  logic        clk, reset, instr_valid, carry_flag, negative_flag, tk, br;
  logic        pc_load, flush_prefetch, busy, branch_done;
  logic [15:0] instr_word;
  logic [20:0] pc_next, pc_load_value;
  logic [1:0]  phase;
  logic [7:0]  ops [4] = '{CFBU_OP_CARRY_CLEAR, CFBU_OP_NEGATIVE_SET,
                           CFBU_OP_NEGATIVE_CLEAR, 8'h12};
  logic [31:0] rng = 32'h4f;
  int          failures, n_checks, bpc, off, k;
  cfbu_core u_cfbu_core (.clk(clk), .reset(reset), .instr_valid(instr_valid),
    .instr_word(instr_word), .pc_next(pc_next), .carry_flag(carry_flag),
    .negative_flag(negative_flag), .pc_load_value(pc_load_value), .pc_load(pc_load),
    .flush_prefetch(flush_prefetch), .busy(busy), .branch_done(branch_done), .phase(phase));
  cfbu_fetch_model u_cfbu_fetch_model (.clk(clk), .reset(reset), .phase(phase), .busy(busy),
    .pc_load(pc_load), .pc_load_value(pc_load_value), .pc_next(pc_next));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input string nm, input logic [20:0] e, input logic [20:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // The clock; the watchdog allows about ten times the run.
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  initial begin
    #60000 failures++;
    give_verdict;
  end
  // Words are held for the whole cycle, so the flag sampling phase does not matter.
  initial begin
    {reset, instr_valid, instr_word, carry_flag, negative_flag, bpc} = {1'b1, 19'h0, 32'h100};
    step(8);
    reset = 0;
    for (int i = 0; i < 60; i++) begin
      rng = xs(rng);
      k = (i < 3) ? i : rng[1:0];
      instr_valid = (i < 3) || rng[31:29] != 3'h0;
      instr_word = {ops[k], (i == 0) ? 8'h80 : (i == 1) ? 8'h7f : rng[15:8]};
      carry_flag = (i < 3) ? 1'b0 : rng[2];
      negative_flag = (i < 3) ? (i == 1) : rng[3];
      br = instr_valid && k < 3;
      tk = br && (k == 0 ? !carry_flag : k == 1 ? negative_flag : !negative_flag);
      off = $signed(instr_word[7:0]);
      chk("pc_next", 21'(bpc + 2), pc_next);
      step(3);
      chk("pc_load", tk, pc_load);
      chk("phase", CFBU_PH_WRITE, phase);
      if (tk) chk("pc_load_value", 21'(bpc + 2 + 2 * off), pc_load_value);
      bpc = tk ? bpc + 2 + 2 * off : bpc + 2;
      step(1);
      chk("flush_prefetch", tk, flush_prefetch);
      chk("busy", tk, busy);
      if (tk) step(4);
      chk("branch_done", br, branch_done);
    end
    $display("test random_branches done");
    give_verdict;
  end
endmodule
